// *** design/irf_device.sv ***
// Purpose: Request flags for external pins, wakeup pins and peripherals.
// Assumes: Pin and peripheral inputs are synchronous to clk_i.
// Notes:   Flags hold until software writes zero; enables gate requests.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module irf_device
    import irf_pkg::*;
#(
    parameter bit HAS_IRQ2    = 1'b1,
    parameter bit HAS_TIMER_C = 1'b1
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Register side
    irf_bus_if.device       bus,
    // External request pins
    input  wire logic [4:0] irq_pin_i,
    input  wire logic [4:0] irq_pin_mode_i,
    input  wire logic [4:0] irq_rising_i,
    // Wakeup pins
    input  wire logic [7:0] wakeup_pin_i,
    input  wire logic [7:0] wakeup_pin_mode_i,
    // Direct transfer and converter
    input  wire logic       direct_transfer_enable_i,
    input  wire logic       direct_transfer_after_sleep_i,
    input  wire logic       adc_start_busy_i,
    // Timer F
    input  wire logic       timer_f_16bit_i,
    input  wire logic [7:0] timer_f_low_counter_i,
    input  wire logic [7:0] timer_f_high_counter_i,
    input  wire logic [7:0] timer_f_low_compare_i,
    input  wire logic [7:0] timer_f_high_compare_i,
    // Timers C and B
    input  wire logic [7:0] timer_c_count_i,
    input  wire logic [7:0] timer_b_count_i,
    // Flag mirrors
    output logic      [4:0] first_flags_o,
    output logic      [7:0] periph_flags_o,
    output logic      [7:0] wake_flags_o
);
    // ----------------------------------------
    // History of the watched inputs
    // ----------------------------------------
    // The history is not trusted in the first cycle after reset, so a pin or
    // counter that already sits at a trigger value cannot fake an edge.
    logic       primed;
    logic [4:0] irq_prev;
    logic [7:0] wake_prev;
    logic       busy_prev;
    logic       fh_match_prev;
    logic       fl_match_prev;
    logic [7:0] tc_prev;
    logic [7:0] tb_prev;

    wire fh_match_8  = timer_f_high_counter_i == timer_f_high_compare_i;
    wire fh_match_16 = {timer_f_high_counter_i, timer_f_low_counter_i}
                       == {timer_f_high_compare_i, timer_f_low_compare_i};
    wire fh_match    = timer_f_16bit_i ? fh_match_16 : fh_match_8;
    wire fl_match    = !timer_f_16bit_i && (timer_f_low_counter_i == timer_f_low_compare_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primed        <= 1'b0;
            irq_prev      <= 5'h00;
            wake_prev     <= 8'h00;
            busy_prev     <= 1'b0;
            fh_match_prev <= 1'b0;
            fl_match_prev <= 1'b0;
            tc_prev       <= 8'h00;
            tb_prev       <= 8'h00;
        end else begin
            primed        <= 1'b1;
            irq_prev      <= irq_pin_i;
            wake_prev     <= wakeup_pin_i;
            busy_prev     <= adc_start_busy_i;
            fh_match_prev <= fh_match;
            fl_match_prev <= fl_match;
            tc_prev       <= timer_c_count_i;
            tb_prev       <= timer_b_count_i;
        end
    end

    // ----------------------------------------
    // Set conditions
    // ----------------------------------------
    wire [7:0] irq_edges  = irf_edge({3'h0, irq_prev}, {3'h0, irq_pin_i}, {3'h0, irq_rising_i});
    wire [4:0] irq_keep   = {2'b11, HAS_IRQ2, 2'b11};
    wire [4:0] set_first  = {5{primed}} & irq_edges[4:0] & irq_pin_mode_i & irq_keep;
    wire [7:0] wake_edges = irf_edge(wake_prev, wakeup_pin_i, 8'h00);
    wire [7:0] set_wake   = {8{primed}} & wake_edges & wakeup_pin_mode_i;

    wire set_dt  = direct_transfer_enable_i && direct_transfer_after_sleep_i;
    wire set_ad  = primed && busy_prev && !adc_start_busy_i;
    wire set_tfh = primed && fh_match && !fh_match_prev;
    wire set_tfl = primed && fl_match && !fl_match_prev;
    wire tc_over  = (tc_prev == 8'hff) && (timer_c_count_i == 8'h00);
    wire tc_under = (tc_prev == 8'h00) && (timer_c_count_i == 8'hff);
    wire set_tc  = HAS_TIMER_C && primed && (tc_over || tc_under);
    wire set_tb  = primed && (tb_prev == 8'hff) && (timer_b_count_i == 8'h00);

    // Reserved positions 5 and 4 are never set and so always read zero.
    logic [7:0] set_periph;
    always_comb begin
        set_periph              = 8'h00;
        set_periph[IRF_BIT_DT]  = set_dt;
        set_periph[IRF_BIT_AD]  = set_ad;
        set_periph[IRF_BIT_TFH] = set_tfh;
        set_periph[IRF_BIT_TFL] = set_tfl;
        set_periph[IRF_BIT_TC]  = set_tc;
        set_periph[IRF_BIT_TB]  = set_tb;
    end

    // ----------------------------------------
    // Register writes and flag banks
    // ----------------------------------------
    wire wr_first  = bus.reg_wr && (bus.reg_addr == IRF_IDX_FIRST);
    wire wr_periph = bus.reg_wr && (bus.reg_addr == IRF_IDX_PERIPH);
    wire wr_wake   = bus.reg_wr && (bus.reg_addr == IRF_IDX_WAKE);

    irf_flag_bank #(.W(5)) u_first (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (set_first),
        .wr_i    (wr_first),
        .wdata_i (bus.reg_wdata[4:0]),
        .flags_o (first_flags_o)
    );

    irf_flag_bank #(.W(8)) u_periph (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (set_periph),
        .wr_i    (wr_periph),
        .wdata_i (bus.reg_wdata),
        .flags_o (periph_flags_o)
    );

    irf_flag_bank #(.W(8)) u_wake (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (set_wake),
        .wr_i    (wr_wake),
        .wdata_i (bus.reg_wdata),
        .flags_o (wake_flags_o)
    );

    // ----------------------------------------
    // Read-back, answer and gated requests
    // ----------------------------------------
    // Bits 7 and 6 of the first register belong to other sources and read
    // zero here; bit 5 reads one.
    wire [7:0] rd_mux = (bus.reg_addr == IRF_IDX_FIRST)  ? (IRF_FIRST_READ_ONES | {3'h0, first_flags_o}) :
                        (bus.reg_addr == IRF_IDX_PERIPH) ? periph_flags_o :
                        (bus.reg_addr == IRF_IDX_WAKE)   ? wake_flags_o : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus.reg_rdata  <= 8'h00;
            bus.reg_ack    <= 1'b0;
            bus.req_ext    <= 5'h00;
            bus.req_periph <= 8'h00;
            bus.req_wake   <= 1'b0;
        end else begin
            bus.reg_ack    <= bus.reg_wr || bus.reg_rd;
            bus.reg_rdata  <= bus.reg_rd ? rd_mux : 8'h00;
            bus.req_ext    <= first_flags_o & bus.enable1[4:0];
            bus.req_periph <= periph_flags_o & bus.enable2 & ~IRF_PERIPH_RSVD_MASK;
            bus.req_wake   <= (|wake_flags_o) && bus.enable1[IRF_BIT_WAKE_EN];
        end
    end
endmodule

// *** design/irf_flag_bank.sv ***
// Purpose: Bank of sticky request flags, cleared by writing zero.
// Assumes: set_i bits are one-cycle event pulses.
// Notes:   An event in the clearing cycle keeps its flag.
`timescale 1ns/100ps
module irf_flag_bank
    import irf_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Events and software write
    input  wire logic [W-1:0] set_i,
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    // Flags
    output logic      [W-1:0] flags_o
);
    // Registers are at most one byte wide on the link.
    if (W < 1 || W > 8) begin : g_width_check
        $error("irf_flag_bank: W must be 1..8");
    end

    wire [W-1:0] clear_mask = wr_i ? ~wdata_i : '0;
    wire [W-1:0] next_flags = set_i | (flags_o & ~clear_mask);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= IRF_FLAG_RESET[W-1:0];
        end else begin
            flags_o <= next_flags;
        end
    end
endmodule

// *** design/irf_host.sv ***
// Purpose: Avalon-MM front end that drives the flag block and its enables.
// Assumes: Master holds a request until it samples waitrequest low.
// Notes:   Device accesses answer in three edges, local ones in one.
`timescale 1ns/100ps
module irf_host
    import irf_pkg::*;
#(
    parameter bit REDUCED = 1'b0
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Interrupt
    output logic             irq_o,
    // Flag block side
    irf_bus_if.host          bus
);
    irf_host_state_e state;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] grp_prev;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire        req       = avs_read_i || avs_write_i;
    wire        is_first  = avs_address_i == IRF_AV_FIRST;
    wire        is_periph = avs_address_i == IRF_AV_PERIPH;
    wire        is_wake   = avs_address_i == IRF_AV_WAKE;
    wire        is_dev    = is_first || is_periph || is_wake;
    wire [1:0]  dev_idx   = is_first ? IRF_IDX_FIRST : (is_periph ? IRF_IDX_PERIPH : IRF_IDX_WAKE);
    // Reserved and absent positions are always written as zero.
    wire [7:0]  periph_keep = ~IRF_PERIPH_RSVD_MASK & ~({7'h00, REDUCED} << IRF_BIT_TC);
    wire [7:0]  first_keep  = 8'h1f & ~({7'h00, REDUCED} << IRF_BIT_IRQ2);
    wire [7:0]  wr_byte   = avs_writedata_i[7:0];
    wire [7:0]  dev_wdata = is_periph ? (wr_byte & periph_keep) :
                            is_first  ? (wr_byte & first_keep) : wr_byte;
    wire [2:0]  grp       = {bus.req_wake, |bus.req_periph, |bus.req_ext};
    wire [2:0]  events    = grp & ~grp_prev;
    wire        wr_local  = (state == IRF_IDLE) && avs_write_i && !is_dev;
    wire        wr_status = wr_local && (avs_address_i == IRF_AV_STATUS);
    wire [2:0]  next_status = events | (status & ~(wr_status ? avs_writedata_i[2:0] : 3'h0));
    wire [31:0] local_rd  = (avs_address_i == IRF_AV_ENABLE1) ? {24'h0, bus.enable1} :
                            (avs_address_i == IRF_AV_ENABLE2) ? {24'h0, bus.enable2} :
                            (avs_address_i == IRF_AV_STATUS)  ? {29'h0, status} :
                            (avs_address_i == IRF_AV_MASK)    ? {29'h0, mask} : 32'h0;

    // ----------------------------------------
    // Local registers and interrupt
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus.enable1 <= IRF_ENABLE_RESET;
            bus.enable2 <= IRF_ENABLE_RESET;
            mask        <= IRF_STATUS_RESET;
            status      <= IRF_STATUS_RESET;
            grp_prev    <= 3'h0;
            irq_o       <= 1'b0;
        end else begin
            if (wr_local && avs_address_i == IRF_AV_ENABLE1) begin
                bus.enable1 <= wr_byte & ~({7'h00, REDUCED} << IRF_BIT_IRQ2);
            end
            if (wr_local && avs_address_i == IRF_AV_ENABLE2) begin
                bus.enable2 <= wr_byte & periph_keep;
            end
            if (wr_local && avs_address_i == IRF_AV_MASK) begin
                mask <= avs_writedata_i[2:0];
            end
            status   <= next_status;
            grp_prev <= grp;
            irq_o    <= |(next_status & mask);
        end
    end

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state             <= IRF_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
            bus.reg_addr      <= IRF_IDX_FIRST;
            bus.reg_wr        <= 1'b0;
            bus.reg_rd        <= 1'b0;
            bus.reg_wdata     <= 8'h00;
        end else begin
            bus.reg_wr <= 1'b0;
            bus.reg_rd <= 1'b0;
            case (state)
                IRF_IDLE: begin
                    if (req && is_dev) begin
                        bus.reg_addr  <= dev_idx;
                        bus.reg_wdata <= dev_wdata;
                        bus.reg_wr    <= avs_write_i;
                        bus.reg_rd    <= avs_read_i;
                        state         <= IRF_WAIT;
                    end else if (req) begin
                        avs_readdata_o    <= avs_read_i ? local_rd : 32'h0;
                        avs_waitrequest_o <= 1'b0;
                        state             <= IRF_DONE;
                    end
                end
                IRF_WAIT: begin
                    if (bus.reg_ack) begin
                        avs_readdata_o    <= {24'h0, bus.reg_rdata};
                        avs_waitrequest_o <= 1'b0;
                        state             <= IRF_DONE;
                    end
                end
                IRF_DONE: begin
                    avs_waitrequest_o <= 1'b1;
                    state             <= IRF_IDLE;
                end
                default: begin
                    state <= IRF_IDLE;
                end
            endcase
        end
    end
endmodule

// *** shared/irf_bus_if.sv ***
// Purpose: Link between the flag block and its register-side controller.
// Assumes: Both ends on clk_i.
// Notes:   Strobes are one-cycle pulses; ack answers one cycle later.
`timescale 1ns/100ps
interface irf_bus_if;
    logic [1:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_ack;
    logic [7:0] enable1;
    logic [7:0] enable2;
    logic [4:0] req_ext;
    logic [7:0] req_periph;
    logic       req_wake;

    modport device (
        input  reg_addr, reg_wr, reg_rd, reg_wdata, enable1, enable2,
        output reg_rdata, reg_ack, req_ext, req_periph, req_wake
    );
    modport host (
        output reg_addr, reg_wr, reg_rd, reg_wdata, enable1, enable2,
        input  reg_rdata, reg_ack, req_ext, req_periph, req_wake
    );
endinterface

// *** shared/irf_pkg.sv ***
// Purpose: Shared constants and types for the interrupt request flag block.
// Assumes: One 125 MHz clock, synchronous active-high reset.
// Notes:   Indices, offsets, field positions and the edge helper.
// Function
// - External pin edge sets flags 4,3,1,0.
// - Only zero writes clear; ones ignored.
// - Pin 2 edge sets bit 2; reduced keeps 0.
// - Peripheral register is 8 bits, fixed layout.
// - Accepting an interrupt never clears flags.
// - Direct transfer after sleep sets bit 7.
// - Converter done, busy cleared, sets bit 6.
// - Software writes zero to bits 5, 4.
// - Timer F high or 16-bit match sets bit 3.
// - Timer F low match in 8-bit mode.
// - Timer C wrap either way sets bit 1.
// - Timer B overflow sets bit 0.
// - Falling wakeup pin edge sets wakeup flag.
// - Reduced variant keeps timer C flag cleared.
// - Requests pass only while enable bit set.
package irf_pkg;

    // ----------------------------------------
    // Device register indices
    // ----------------------------------------
    localparam logic [1:0] IRF_IDX_FIRST  = 2'h0;
    localparam logic [1:0] IRF_IDX_PERIPH = 2'h1;
    localparam logic [1:0] IRF_IDX_WAKE   = 2'h2;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int IRF_BIT_DT        = 7;
    localparam int IRF_BIT_AD        = 6;
    localparam int IRF_BIT_TFH       = 3;
    localparam int IRF_BIT_TFL       = 2;
    localparam int IRF_BIT_TC        = 1;
    localparam int IRF_BIT_TB        = 0;
    localparam int IRF_BIT_IRQ2      = 2;
    localparam int IRF_BIT_WAKE_EN   = 5;
    localparam int IRF_ST_EXT        = 0;
    localparam int IRF_ST_PERIPH     = 1;
    localparam int IRF_ST_WAKE       = 2;

    // ----------------------------------------
    // Reset and fixed values
    // ----------------------------------------
    localparam logic [7:0] IRF_FLAG_RESET       = 8'h00;
    localparam logic [7:0] IRF_ENABLE_RESET     = 8'h00;
    localparam logic [7:0] IRF_FIRST_READ_ONES  = 8'h20;
    localparam logic [7:0] IRF_PERIPH_RSVD_MASK = 8'h30;
    localparam logic [2:0] IRF_STATUS_RESET     = 3'h0;

    // ----------------------------------------
    // Host register byte offsets
    // ----------------------------------------
    localparam logic [4:0] IRF_AV_FIRST   = 5'h00;
    localparam logic [4:0] IRF_AV_PERIPH  = 5'h04;
    localparam logic [4:0] IRF_AV_WAKE    = 5'h08;
    localparam logic [4:0] IRF_AV_ENABLE1 = 5'h0c;
    localparam logic [4:0] IRF_AV_ENABLE2 = 5'h10;
    localparam logic [4:0] IRF_AV_STATUS  = 5'h14;
    localparam logic [4:0] IRF_AV_MASK    = 5'h18;

    typedef enum logic [1:0] {
        IRF_IDLE = 2'b00,
        IRF_WAIT = 2'b01,
        IRF_DONE = 2'b10
    } irf_host_state_e;

    // Per-bit edge: rise selects low-to-high, otherwise high-to-low.
    function automatic logic [7:0] irf_edge(input logic [7:0] prev, input logic [7:0] cur,
                                            input logic [7:0] rise);
        irf_edge = (rise & ~prev & cur) | (~rise & prev & ~cur);
    endfunction

endpackage

// *** verification/irf_link_sva.sv ***
// Purpose: Link checks between the host front end and the flag block.
// Assumes: One clock; rst_i synchronous and active high.
// Notes:   Flags are seen only through req_* and reg_rdata on the link.
`timescale 1ns/100ps
module irf_link_sva
    import irf_pkg::*;
(
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Link signals
    input wire logic [1:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_ack,
    input wire logic [7:0] enable1,
    input wire logic [7:0] enable2,
    input wire logic [4:0] req_ext,
    input wire logic [7:0] req_periph,
    input wire logic       req_wake
);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic periph_wr = reg_wr && (reg_addr == IRF_IDX_PERIPH);
    sequence s_strobe;
        reg_wr || reg_rd;
    endsequence
    sequence s_answer;
        reg_ack ##1 !reg_ack;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    ack_follows_strobe_a: assert property (s_strobe |=> s_answer)
        else $error("link ack missing one cycle after strobe");
    ack_has_cause_a: assert property (reg_ack |-> $past(reg_wr) || $past(reg_rd))
        else $error("link ack without a strobe");
    strobe_single_a: assert property (s_strobe |=> !reg_wr && !reg_rd)
        else $error("link strobe longer than one cycle");
    rdata_idle_a: assert property (!reg_ack |-> reg_rdata == 8'h00)
        else $error("link read data not zero outside ack");
    first_fixed_bits_a: assert property ((reg_rd && reg_addr == IRF_IDX_FIRST) |=> reg_rdata[7:5] == 3'h1)
        else $error("first register fixed bits wrong");
    periph_rsvd_read_a: assert property ((reg_rd && reg_addr == IRF_IDX_PERIPH) |=> reg_rdata[5:4] == 2'h0)
        else $error("peripheral reserved bits read nonzero");
    periph_gate_a: assert property ((req_periph & ~$past(enable2)) == 8'h00)
        else $error("peripheral request without enable");
    ext_gate_a: assert property (({3'h0, req_ext} & ~$past(enable1)) == 8'h00)
        else $error("pin request without enable");
    wake_gate_a: assert property (req_wake |-> $past(enable1[5]))
        else $error("wakeup request without enable");
    // A request may only fall after a clearing write two samples back or an enable change; else an event is lost.
    periph_sticky_a: assert property ((|($past(req_periph) & ~req_periph)) |->
        $past(periph_wr, 2) || ($past(enable2) != $past(enable2, 2)))
        else $error("peripheral request fell without a clear");
endmodule

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the host front end and flag block on one link.
// Assumes: 125 MHz clock; rst_i held 12 cycles.
// Notes:   Reads queue their expectation; a watcher compares when the read completes.
`timescale 1ns/100ps
module testbench
    import irf_pkg::*;
();
    typedef struct {logic [31:0] v; string n;} irf_note_s;
    logic        clk_i;
    logic        rst_i;
    logic [4:0]  av_addr;
    logic        av_rd;
    logic        av_wr;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic        irq;
    logic [4:0]  pin;
    logic [4:0]  rise;
    logic [4:0]  pmode;
    logic [4:0]  first_fl;
    logic [7:0]  periph_fl;
    logic [7:0]  wake_fl;
    logic [7:0]  wk_pin;
    logic [7:0]  wk_mode;
    logic        dt_en;
    logic        dt_go;
    logic        busy;
    logic        f16;
    logic [7:0]  fl;
    logic [7:0]  fh;
    logic [7:0]  tc;
    logic [7:0]  tb;
    logic [31:0] seed;
    logic [31:0] r;
    int          n_errors;
    int          check_count;
    int          cycles;
    irf_note_s   q[$];
    irf_note_s   note;
    irf_bus_if   link();

    irf_host i_irf_host (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(av_addr), .avs_read_i(av_rd),
        .avs_write_i(av_wr), .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
        .avs_waitrequest_o(av_wait), .irq_o(irq), .bus(link.host));
    irf_device i_irf_device (.clk_i(clk_i), .rst_i(rst_i), .bus(link.device), .irq_pin_i(pin),
        .irq_pin_mode_i(pmode), .irq_rising_i(rise), .wakeup_pin_i(wk_pin), .wakeup_pin_mode_i(wk_mode),
        .direct_transfer_enable_i(dt_en), .direct_transfer_after_sleep_i(dt_go), .adc_start_busy_i(busy),
        .timer_f_16bit_i(f16), .timer_f_low_counter_i(fl), .timer_f_high_counter_i(fh),
        .timer_f_low_compare_i(8'h55), .timer_f_high_compare_i(8'haa), .timer_c_count_i(tc),
        .timer_b_count_i(tb), .first_flags_o(first_fl), .periph_flags_o(periph_fl), .wake_flags_o(wake_fl));
    irf_link_sva i_irf_link_sva (.clk_i(clk_i), .rst_i(rst_i), .reg_addr(link.reg_addr), .reg_wr(link.reg_wr),
        .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
        .enable1(link.enable1), .enable2(link.enable2), .req_ext(link.req_ext), .req_periph(link.req_periph),
        .req_wake(link.req_wake));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string n);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // The request stands until waitrequest is sampled low; only the cycle ceiling ends a hung wait.
    task automatic acc(input logic [4:0] a, input logic w, input logic [7:0] d);
        av_addr  <= a;
        av_wr    <= w;
        av_rd    <= !w;
        av_wdata <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (av_wait !== 1'b0);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
        q.push_back('{{24'h0, e}, n});
        acc(a, 1'b0, 8'h00);
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (av_rd === 1'b1 && av_wait === 1'b0 && q.size() > 0) begin
            note = q.pop_front();
            check(av_rdata, note.v, note.n);
        end
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 32'd62;
        r = xs();
        {rst_i, av_addr, av_rd, av_wr, av_wdata} = {1'b1, 5'h00, 1'b0, 1'b0, 32'h0};
        {n_errors, check_count, cycles} = {32'd0, 32'd0, 32'd0};
        rise = r[4:0];
        pmode = 5'h1f;
        pin = r[4:0];
        wk_pin = 8'hff;
        wk_mode = r[15:8] | 8'h01;
        {dt_en, dt_go, busy, f16} = 4'h0;
        {fl, fh, tc, tb} = {8'h00, 8'h00, 8'h10, 8'h10};
        tick(12);
        rst_i <= 1'b0;
        tick(2);
        acc(IRF_AV_ENABLE1, 1'b1, 8'h3f);
        acc(IRF_AV_ENABLE2, 1'b1, 8'hcf);
        pin <= ~rise;
        tick(2);
        rd(IRF_AV_FIRST, IRF_FIRST_READ_ONES, "pin wrong edge");
        pin <= rise;
        tick(2);
        rd(IRF_AV_FIRST, 8'h3f, "pin edges");
        acc(IRF_AV_FIRST, 1'b1, 8'h1a);
        rd(IRF_AV_FIRST, 8'h3a, "zero write clears");
        r = xs();
        acc(IRF_AV_FIRST, 1'b1, r[7:0]);
        rd(IRF_AV_FIRST, 8'h20 | (8'h1a & r[7:0]), "random clear");
        rd(IRF_AV_FIRST, 8'h20 | (8'h1a & r[7:0]), "read keeps flags");
        check({27'h0, first_fl}, {27'h0, 5'h1a & r[4:0]}, "first mirror");
        {pmode, pin} <= {5'h00, ~rise};
        tick(2);
        pin <= rise;
        tick(2);
        rd(IRF_AV_FIRST, 8'h20 | (8'h1a & r[7:0]), "mode off ignores edge");
        pmode <= 5'h1f;
        dt_go <= 1'b1;
        {tc, tb, busy} <= {8'hff, 8'hff, 1'b1};
        tick(1);
        {dt_go, dt_en} <= 2'b01;
        {tc, tb, busy, fh, fl} <= {8'h00, 8'h00, 1'b0, 8'haa, 8'h55};
        tick(1);
        dt_go <= 1'b1;
        tick(1);
        {dt_go, fh, fl} <= {1'b0, 8'h00, 8'h00};
        tick(2);
        rd(IRF_AV_PERIPH, 8'hcf, "peripheral events");
        check({24'h0, periph_fl}, 32'hcf, "peripheral mirror");
        acc(IRF_AV_PERIPH, 1'b1, 8'hff);
        rd(IRF_AV_PERIPH, 8'hcf, "ones write ignored");
        acc(IRF_AV_PERIPH, 1'b1, 8'h00);
        rd(IRF_AV_PERIPH, 8'h00, "peripheral cleared");
        {tc, tb, f16, fl} <= {8'hff, 8'hff, 1'b1, 8'h55};
        tick(2);
        fh <= 8'haa;
        tick(2);
        rd(IRF_AV_PERIPH, 8'h0a, "underflow and wide match");
        fork
            acc(IRF_AV_PERIPH, 1'b1, 8'h00);
            begin
                tick(1);
                dt_go <= 1'b1;
                tick(1);
                dt_go <= 1'b0;
            end
        join
        rd(IRF_AV_PERIPH, 8'h80, "set beats clear");
        wk_pin <= 8'h00;
        tick(2);
        rd(IRF_AV_WAKE, wk_mode, "wakeup falling");
        wk_pin <= 8'hff;
        tick(2);
        rd(IRF_AV_WAKE, wk_mode, "wakeup rising ignored");
        check({24'h0, wake_fl}, {24'h0, wk_mode}, "wakeup mirror");
        acc(IRF_AV_WAKE, 1'b1, 8'h00);
        acc(IRF_AV_STATUS, 1'b1, 8'h07);
        rd(IRF_AV_STATUS, 8'h00, "status cleared");
        acc(IRF_AV_MASK, 1'b1, 8'h03);
        wk_pin <= 8'h00;
        tick(3);
        rd(IRF_AV_STATUS, 8'h04, "wakeup status");
        check({31'h0, irq}, 32'h0, "masked irq");
        acc(IRF_AV_MASK, 1'b1, 8'h07);
        tick(2);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        acc(IRF_AV_STATUS, 1'b1, 8'h04);
        tick(2);
        check({31'h0, irq}, 32'h0, "irq after clear");
        rd(5'h1c, 8'h00, "unmapped read");
        report_and_stop();
    end
endmodule
